// >>> tcc_edge.sv
// Two-flop synchroniser followed by an edge detector for an outside signal.
module tcc_edge (
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic async_i,
	output logic level_o,
	output logic rise_o,
	output logic fall_o
);

	logic meta;
	logic sync;
	logic prev;

	always_ff @(posedge mclk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			meta <= 1'b0;
			sync <= 1'b0;
			prev <= 1'b0;
		end
		else
		begin
			meta <= async_i;
			sync <= meta;
			prev <= sync;
		end
	end

	assign level_o = sync;
	assign rise_o = sync & ~prev;
	assign fall_o = ~sync & prev;

endmodule // tcc_edge

// >>> tcc_pins.sv
module tcc_pins (
	input wire logic mclk_i,
	input wire logic run_i,
	output logic [2:0] ext_clock_pins_o,
	output logic [2:0] io_line_a_all_o,
	output logic io_line_b_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// ********
	// Outside clock and line drivers
	// ********
	logic clk = 1'b0;
	logic gate = 1'b0;
	logic line_a = 1'b0;
	int ph = 0;

	// Each level lasts three master periods, which keeps the rate at a sixth
	// of the master clock; the clock stands still while run_i is low.
	always @(negedge mclk_i)
	begin
		ph <= (run_i && ph < 2) ? ph + 1 : 0;
		if (run_i && ph == 2)
			clk <= ~clk;
	end

	assign ext_clock_pins_o = {1'b0, gate, clk};
	assign io_line_a_all_o = {clk, clk, line_a};
	assign io_line_b_o = 1'b0;

	task pulse_a(input int w);
		@(negedge mclk_i);
		line_a = 1'b1;
		repeat (w) @(negedge mclk_i);
		line_a = 1'b0;
	endtask

endmodule // tcc_pins

// >>> tcc_pkg.sv
package tcc_pkg;

	// ****************************************
	// Widths and encodings
	// ****************************************
	localparam int CNT_W = 16;
	localparam logic [15:0] CNT_MAX = 16'hFFFF;
	localparam logic [15:0] CNT_RESET = 16'h0000;

	// Clock source select codes: five internal clocks, then three chained inputs.
	localparam logic [2:0] CLKSEL_DIV2 = 3'h0;
	localparam logic [2:0] CLKSEL_DIV8 = 3'h1;
	localparam logic [2:0] CLKSEL_DIV32 = 3'h2;
	localparam logic [2:0] CLKSEL_DIV128 = 3'h3;
	localparam logic [2:0] CLKSEL_SLOW = 3'h4;
	localparam logic [2:0] CLKSEL_XC0 = 3'h5;
	localparam logic [2:0] CLKSEL_XC1 = 3'h6;
	localparam logic [2:0] CLKSEL_XC2 = 3'h7;

	// Prescaler taps on a free-running divider counter.
	localparam int DIV_W = 7;
	localparam int TAP_DIV2 = 0;
	localparam int TAP_DIV8 = 2;
	localparam int TAP_DIV32 = 4;
	localparam int TAP_DIV128 = 6;

	// Burst gate codes.
	localparam logic [1:0] BURST_NONE = 2'h0;
	localparam logic [1:0] BURST_XC0 = 2'h1;
	localparam logic [1:0] BURST_XC1 = 2'h2;
	localparam logic [1:0] BURST_XC2 = 2'h3;

	// Edge codes for load and trigger edge fields.
	localparam logic [1:0] EDGE_NONE = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;

	// Waveform external event source codes.
	localparam logic [1:0] EEVT_LINE_B = 2'h0;
	localparam logic [1:0] EEVT_XC0 = 2'h1;
	localparam logic [1:0] EEVT_XC1 = 2'h2;
	localparam logic [1:0] EEVT_XC2 = 2'h3;

	// Block-level chaining select: pin or another channel's line A.
	localparam logic [1:0] CHAIN_PIN = 2'h0;
	localparam logic [1:0] CHAIN_LINE_A_1 = 2'h2;
	localparam logic [1:0] CHAIN_LINE_A_2 = 2'h3;

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic [2:0] clock_source_select;
		logic clock_invert;
		logic [1:0] burst;
		logic wave;
		logic disable_on_b_load;
		logic stop_on_b_load;
		logic disable_on_c_match;
		logic stop_on_c_match;
		logic trigger_on_c_match;
		logic trig_on_line_a;
		logic [1:0] ext_trigger_edge;
		logic [1:0] load_a_edge;
		logic [1:0] load_b_edge;
		logic [1:0] eevt_src;
		logic [1:0] eevt_edge;
		logic event_trigger_enable;
	} tcc_mode_s;

	typedef struct packed {
		logic clock_enable_cmd;
		logic clock_disable_cmd;
		logic soft_trigger_cmd;
	} tcc_cmd_s;

	typedef struct packed {
		logic overflow_flag;
		logic load_overrun_flag;
		logic clock_running_flag;
		logic load_a_flag;
		logic load_b_flag;
		logic c_match_flag;
		logic ext_trig_flag;
	} tcc_status_s;

endpackage

// >>> tcc_timer.sv
module tcc_timer #(
	parameter int CW = tcc_pkg::CNT_W,
	parameter int CH = 0
) (
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic slow_clock_i,
	input wire logic [2:0] ext_clock_pins_i,
	input wire logic [2:0] io_line_a_all_i,
	input wire logic [5:0] chain_select_i,
	input wire logic io_line_b_i,
	input wire tcc_pkg::tcc_mode_s mode_i,
	input wire tcc_pkg::tcc_cmd_s cmd_i,
	input wire logic block_sync_i,
	input wire logic [CW-1:0] compare_c_i,
	input wire logic read_capture_a_i,
	input wire logic read_capture_b_i,
	input wire logic read_status_i,
	output logic [CW-1:0] counter_value_o,
	output logic [CW-1:0] capture_a_o,
	output logic [CW-1:0] capture_b_o,
	output tcc_pkg::tcc_status_s status_o,
	output logic line_a_oe_n_o,
	output logic line_b_oe_n_o
);

	// ****************************************
	// Input synchronisation
	// ****************************************
	logic [2:0] pin_level;
	logic [2:0] la_level;
	logic slow_level;
	logic slow_rise;
	logic slow_fall;
	logic a_level;
	logic a_rise;
	logic a_fall;
	logic b_level;
	logic b_rise;
	logic b_fall;

	// Every outside signal passes two flops before logic reads it.
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_sync
			tcc_edge u_pin (.mclk_i(mclk_i), .reset_i(reset_i), .async_i(ext_clock_pins_i[gi]),
				.level_o(pin_level[gi]), .rise_o(), .fall_o());
			tcc_edge u_la (.mclk_i(mclk_i), .reset_i(reset_i), .async_i(io_line_a_all_i[gi]),
				.level_o(la_level[gi]), .rise_o(), .fall_o());
		end
	endgenerate

	tcc_edge u_slow (.mclk_i(mclk_i), .reset_i(reset_i), .async_i(slow_clock_i),
		.level_o(slow_level), .rise_o(slow_rise), .fall_o(slow_fall));
	tcc_edge u_a (.mclk_i(mclk_i), .reset_i(reset_i), .async_i(io_line_a_all_i[CH]),
		.level_o(a_level), .rise_o(a_rise), .fall_o(a_fall));
	tcc_edge u_b (.mclk_i(mclk_i), .reset_i(reset_i), .async_i(io_line_b_i),
		.level_o(b_level), .rise_o(b_rise), .fall_o(b_fall));

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
		edge_hit = (sel == tcc_pkg::EDGE_RISE && r) || (sel == tcc_pkg::EDGE_FALL && f)
			|| (sel == tcc_pkg::EDGE_BOTH && (r || f));
	endfunction

	// Chained input from a pin or from another channel's line A, per 2-bit field.
	function automatic logic chain_pick(input logic [1:0] sel, input logic pin,
		input logic [2:0] la, input int ch);
		chain_pick = pin;
		if (sel == tcc_pkg::CHAIN_LINE_A_1)
			chain_pick = la[(ch + 1) % 3];
		else if (sel == tcc_pkg::CHAIN_LINE_A_2)
			chain_pick = la[(ch + 2) % 3];
	endfunction

	// ****************************************
	// Clock selection
	// ****************************************
	logic [2:0] xc;
	logic [tcc_pkg::DIV_W-1:0] div;
	logic [tcc_pkg::DIV_W-1:0] next_div;
	logic [tcc_pkg::DIV_W-1:0] div_rise;
	logic sel_level;
	logic sel_prev;
	logic sel_edge;
	logic gate_ok;
	logic count_tick;

	assign xc[0] = chain_pick(chain_select_i[1:0], pin_level[0], la_level, 0);
	assign xc[1] = chain_pick(chain_select_i[3:2], pin_level[1], la_level, 1);
	assign xc[2] = chain_pick(chain_select_i[5:4], pin_level[2], la_level, 2);

	// Prescaler: a tap rises once per 2^(tap+1) master clocks.
	assign next_div = div + 1'b1;
	assign div_rise = next_div & ~div;

	// Internal clocks count on their own rising tick; the invert bit then uses the falling tick.
	logic int_rise;
	logic int_fall;
	logic [tcc_pkg::DIV_W-1:0] div_fall;
	assign div_fall = ~next_div & div;

	always_comb
	begin
		int_rise = 1'b0;
		int_fall = 1'b0;
		sel_level = 1'b0;
		unique case (mode_i.clock_source_select)
			tcc_pkg::CLKSEL_DIV2:
			begin
				int_rise = div_rise[tcc_pkg::TAP_DIV2];
				int_fall = div_fall[tcc_pkg::TAP_DIV2];
			end
			tcc_pkg::CLKSEL_DIV8:
			begin
				int_rise = div_rise[tcc_pkg::TAP_DIV8];
				int_fall = div_fall[tcc_pkg::TAP_DIV8];
			end
			tcc_pkg::CLKSEL_DIV32:
			begin
				int_rise = div_rise[tcc_pkg::TAP_DIV32];
				int_fall = div_fall[tcc_pkg::TAP_DIV32];
			end
			tcc_pkg::CLKSEL_DIV128:
			begin
				int_rise = div_rise[tcc_pkg::TAP_DIV128];
				int_fall = div_fall[tcc_pkg::TAP_DIV128];
			end
			tcc_pkg::CLKSEL_SLOW:
			begin
				int_rise = slow_rise;
				int_fall = slow_fall;
			end
			tcc_pkg::CLKSEL_XC0: sel_level = xc[0];
			tcc_pkg::CLKSEL_XC1: sel_level = xc[1];
			tcc_pkg::CLKSEL_XC2: sel_level = xc[2];
		endcase
	end

	logic ext_sel;
	assign ext_sel = mode_i.clock_source_select >= tcc_pkg::CLKSEL_XC0;
	assign sel_edge = ext_sel ? (mode_i.clock_invert ? (~sel_level & sel_prev)
		: (sel_level & ~sel_prev))
		: (mode_i.clock_invert ? int_fall : int_rise);

	// Burst gate: the clock passes only while the chosen chained input is high.
	assign gate_ok = (mode_i.burst == tcc_pkg::BURST_NONE) ? 1'b1
		: xc[mode_i.burst - 2'h1];

	// ****************************************
	// Clock control and triggers
	// ****************************************
	logic enabled;
	logic running;
	logic trig_pending;
	logic sw_trig;
	logic c_match;
	logic ext_trig;
	logic any_trig;
	logic c_trig;
	logic cap_a_ok;
	logic cap_b_ok;
	logic load_a;
	logic load_b;
	logic ev_level;
	logic ev_prev;
	logic ev_hit;
	logic [CW-1:0] count;
	logic [CW-1:0] cap_a;
	logic [CW-1:0] cap_b;
	logic a_loaded;
	logic a_unread;
	logic b_unread;
	logic overflow;
	logic overrun;
	logic c_match_seen;
	logic ext_seen;
	logic a_seen;
	logic b_seen;

	assign sw_trig = cmd_i.soft_trigger_cmd | block_sync_i;
	assign c_match = count_tick & (count == compare_c_i);
	assign ev_level = (mode_i.eevt_src == tcc_pkg::EEVT_LINE_B) ? b_level
		: xc[mode_i.eevt_src - 2'h1];
	assign ev_hit = edge_hit(mode_i.eevt_edge, ev_level & ~ev_prev, ~ev_level & ev_prev);

	// Edge field of zero never matches, so the external trigger is off.
	assign ext_trig = mode_i.wave ? (mode_i.event_trigger_enable & ev_hit)
		: (mode_i.trig_on_line_a ? edge_hit(mode_i.ext_trigger_edge, a_rise, a_fall)
		: edge_hit(mode_i.ext_trigger_edge, b_rise, b_fall));
	assign c_trig = mode_i.trigger_on_c_match & c_match;
	assign any_trig = sw_trig | ext_trig | c_trig;

	// Count ticks only while enabled, started and ungated.
	assign count_tick = sel_edge & gate_ok & enabled & running;

	assign cap_a_ok = ~a_loaded;
	assign cap_b_ok = a_loaded;
	assign load_a = ~mode_i.wave & cap_a_ok & edge_hit(mode_i.load_a_edge, a_rise, a_fall);
	assign load_b = ~mode_i.wave & cap_b_ok & edge_hit(mode_i.load_b_edge, a_rise, a_fall);

	logic stop_ev;
	logic dis_ev;
	assign stop_ev = (~mode_i.wave & load_b & mode_i.stop_on_b_load)
		| (mode_i.wave & c_match & mode_i.stop_on_c_match);
	assign dis_ev = (~mode_i.wave & load_b & mode_i.disable_on_b_load)
		| (mode_i.wave & c_match & mode_i.disable_on_c_match);

	always_ff @(posedge mclk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			div <= '0;
			sel_prev <= 1'b0;
			ev_prev <= 1'b0;
			enabled <= 1'b0;
			running <= 1'b0;
			trig_pending <= 1'b0;
			count <= CW'(tcc_pkg::CNT_RESET);
		end
		else
		begin
			div <= next_div;
			sel_prev <= sel_level;
			ev_prev <= ev_level;
			// Disable wins over enable so a stray pair leaves the channel safe.
			if (cmd_i.clock_disable_cmd | dis_ev)
				enabled <= 1'b0;
			else if (cmd_i.clock_enable_cmd)
				enabled <= 1'b1;
			if (enabled & any_trig)
				running <= 1'b1;
			else if (enabled & stop_ev)
				running <= 1'b0;
			// The reset waits for the next active edge of the count clock.
			if (count_tick)
				trig_pending <= 1'b0;
			if (enabled & (sw_trig | ext_trig))
				trig_pending <= 1'b1;
			// A compare trigger already sits on its active edge, so it zeroes the counter there.
			if (count_tick)
				count <= (trig_pending | c_trig) ? CW'(tcc_pkg::CNT_RESET) : count + 1'b1;
		end
	end

	// ****************************************
	// Capture registers and flags
	// ****************************************
	always_ff @(posedge mclk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			cap_a <= '0;
			cap_b <= '0;
			a_loaded <= 1'b0;
			a_unread <= 1'b0;
			b_unread <= 1'b0;
			overflow <= 1'b0;
			overrun <= 1'b0;
			c_match_seen <= 1'b0;
			ext_seen <= 1'b0;
			a_seen <= 1'b0;
			b_seen <= 1'b0;
		end
		else
		begin
			if (load_a)
				cap_a <= count;
			if (load_b)
				cap_b <= count;
			if (any_trig | load_b)
				a_loaded <= 1'b0;
			else if (load_a)
				a_loaded <= 1'b1;
			// Set wins over the read in the same cycle.
			a_unread <= load_a | (a_unread & ~read_capture_a_i);
			b_unread <= load_b | (b_unread & ~read_capture_b_i);
			overrun <= ((load_a & a_unread) | (load_b & b_unread))
				| (overrun & ~read_status_i);
			overflow <= (count_tick & ~(trig_pending | c_trig) & count == CW'(tcc_pkg::CNT_MAX))
				| (overflow & ~read_status_i);
			c_match_seen <= c_match | (c_match_seen & ~read_status_i);
			ext_seen <= ext_trig | (ext_seen & ~read_status_i);
			a_seen <= load_a | (a_seen & ~read_status_i);
			b_seen <= load_b | (b_seen & ~read_status_i);
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign counter_value_o = count;
	assign capture_a_o = cap_a;
	assign capture_b_o = cap_b;
	assign status_o.overflow_flag = overflow;
	assign status_o.load_overrun_flag = overrun;
	assign status_o.clock_running_flag = enabled;
	assign status_o.load_a_flag = a_seen;
	assign status_o.load_b_flag = b_seen;
	assign status_o.c_match_flag = c_match_seen;
	assign status_o.ext_trig_flag = ext_seen;

	// Enables are active low; waveform generation itself lives outside this channel.
	assign line_a_oe_n_o = ~mode_i.wave;
	assign line_b_oe_n_o = ~(mode_i.wave & (mode_i.eevt_src != tcc_pkg::EEVT_LINE_B));

endmodule // tcc_timer

// >>> tcc_timer_asserts.sv
module tcc_timer_asserts #(
	parameter int CW = 16
) (
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire tcc_pkg::tcc_mode_s mode_i,
	input wire tcc_pkg::tcc_cmd_s cmd_i,
	input wire logic read_status_i,
	input wire logic [CW-1:0] counter_value_o,
	input wire tcc_pkg::tcc_status_s status_o,
	input wire logic line_a_oe_n_o,
	input wire logic line_b_oe_n_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// ********
	// Port relations
	// ********
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (reset_i);

	a_enable_runs: assert property (
		cmd_i.clock_enable_cmd && !cmd_i.clock_disable_cmd |=> status_o.clock_running_flag)
		else $error("clock not enabled after enable command");
	a_disable_halts: assert property (
		cmd_i.clock_disable_cmd |=> !status_o.clock_running_flag)
		else $error("clock still enabled after disable command");
	a_off_stays_off: assert property (
		!status_o.clock_running_flag && !cmd_i.clock_enable_cmd |=> !status_o.clock_running_flag)
		else $error("clock enabled without an enable command");
	a_frozen_count: assert property (
		!status_o.clock_running_flag [*2] |=> $stable(counter_value_o))
		else $error("counter moved while its clock was disabled");
	a_count_steps: assert property (
		!$stable(counter_value_o) |->
		counter_value_o == $past(counter_value_o) + 1'b1 || counter_value_o == '0)
		else $error("counter changed by other than one step or a reset");
	a_overflow_holds: assert property (
		status_o.overflow_flag && !read_status_i |=> status_o.overflow_flag)
		else $error("overflow flag lost without a status read");
	a_overrun_holds: assert property (
		status_o.load_overrun_flag && !read_status_i |=> status_o.load_overrun_flag)
		else $error("overrun flag lost without a status read");
	a_line_a_dir: assert property (
		line_a_oe_n_o == !mode_i.wave)
		else $error("line A direction does not follow the mode");
	a_line_b_dir: assert property (
		line_b_oe_n_o == !(mode_i.wave && mode_i.eevt_src != tcc_pkg::EEVT_LINE_B))
		else $error("line B direction does not follow mode and event source");

endmodule // tcc_timer_asserts

bind tcc_timer tcc_timer_asserts #(.CW(CW)) tcc_timer_asserts_inst (
	.mclk_i(mclk_i),
	.reset_i(reset_i),
	.mode_i(mode_i),
	.cmd_i(cmd_i),
	.read_status_i(read_status_i),
	.counter_value_o(counter_value_o),
	.status_o(status_o),
	.line_a_oe_n_o(line_a_oe_n_o),
	.line_b_oe_n_o(line_b_oe_n_o)
);

// >>> tcc_timer_tb.sv
module tcc_timer_tb;
	timeunit 1ns;
	timeprecision 1ps;

	// ********
	// Stimulus and wiring
	// ********
	localparam int CW = 8;
	localparam logic [2:0] EN = 3'b100;
	localparam logic [2:0] DIS = 3'b010;
	localparam logic [2:0] TRG = 3'b001;
	logic mclk_i = 1'b0;
	logic reset_i = 1'b1;
	logic slow = 1'b0;
	logic run = 1'b0;
	logic [5:0] chain = '0;
	tcc_pkg::tcc_mode_s md = '0;
	tcc_pkg::tcc_cmd_s cmd = '0;
	logic sync = 1'b0;
	logic [CW-1:0] cmp = 8'h0A;
	logic [2:0] rd = '0;
	logic [2:0] pins;
	logic [2:0] la;
	logic lb;
	logic [CW-1:0] cnt;
	logic [CW-1:0] ca;
	logic [CW-1:0] cb;
	logic [CW-1:0] v;
	tcc_pkg::tcc_status_s st;
	int err_count = 0;
	int check_count = 0;
	int n;
	int sel[7] = '{0, 1, 2, 3, 4, 5, 5};
	int chs[7] = '{0, 0, 0, 0, 0, 0, 2};
	int per[7] = '{8, 32, 128, 512, 80, 24, 24};

	always #5 mclk_i = ~mclk_i;
	always #100 slow = ~slow;

	tcc_timer #(.CW(CW), .CH(0)) tcc_timer_inst (
		.mclk_i(mclk_i),
		.reset_i(reset_i),
		.slow_clock_i(slow),
		.ext_clock_pins_i(pins),
		.io_line_a_all_i(la),
		.chain_select_i(chain),
		.io_line_b_i(lb),
		.mode_i(md),
		.cmd_i(cmd),
		.block_sync_i(sync),
		.compare_c_i(cmp),
		.read_capture_a_i(rd[0]),
		.read_capture_b_i(rd[1]),
		.read_status_i(rd[2]),
		.counter_value_o(cnt),
		.capture_a_o(ca),
		.capture_b_o(cb),
		.status_o(st),
		.line_a_oe_n_o(),
		.line_b_oe_n_o()
	);

	tcc_pins tcc_pins_inst (
		.mclk_i(mclk_i),
		.run_i(run),
		.ext_clock_pins_o(pins),
		.io_line_a_all_o(la),
		.io_line_b_o(lb)
	);

	task results();
		if (err_count == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e)
		begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task pulse(input tcc_pkg::tcc_cmd_s c, input logic [2:0] r, input logic s);
		@(negedge mclk_i);
		cmd = c;
		rd = r;
		sync = s;
		@(negedge mclk_i);
		cmd = '0;
		rd = '0;
		sync = 1'b0;
	endtask

	task wait_cnt(input logic [CW-1:0] e, input int lim);
		n = 0;
		while (cnt !== e && n < lim)
		begin
			@(negedge mclk_i);
			n++;
		end
		chk("counter", e, cnt);
	endtask

	task cap();
		pulse(EN, 3'b000, 1'b0);
		pulse(TRG, 3'b000, 1'b0);
		repeat (6) @(negedge mclk_i);
		tcc_pins_inst.pulse_a(20);
		repeat (6) @(negedge mclk_i);
	endtask

	// ********
	// Test sequence
	// ********
	initial
	begin
		repeat (10) @(negedge mclk_i);
		reset_i = 1'b0;
		run = 1'b1;
		chk("run_reset", 0, st.clock_running_flag);
		pulse(EN, 3'b000, 1'b0);
		chk("run_enabled", 1, st.clock_running_flag);
		foreach (sel[i])
		begin
			md.clock_source_select = sel[i][2:0];
			chain = chs[i][5:0];
			pulse(TRG, 3'b000, 1'b0);
			wait_cnt(0, 2000);
			wait_cnt(1, 2000);
			n = 0;
			while (cnt !== 8'h05 && n < 2000)
			begin
				@(negedge mclk_i);
				n++;
			end
			chk("tick_period", per[i][15:0], n[15:0]);
		end
		md.clock_source_select = tcc_pkg::CLKSEL_DIV2;
		md.burst = tcc_pkg::BURST_XC1;
		repeat (10) @(negedge mclk_i);
		v = cnt;
		repeat (20) @(negedge mclk_i);
		chk("burst_closed", v, cnt);
		tcc_pins_inst.gate = 1'b1;
		repeat (20) @(negedge mclk_i);
		chk("burst_open", 1, cnt != v);
		md.burst = tcc_pkg::BURST_NONE;
		pulse(3'b000, 3'b000, 1'b1);
		wait_cnt(0, 6);
		pulse(3'b000, 3'b100, 1'b0);
		chk("ovf_clear", 0, st.overflow_flag);
		wait_cnt(8'hFF, 600);
		wait_cnt(0, 4);
		repeat (2) @(negedge mclk_i);
		chk("ovf_set", 1, st.overflow_flag);
		md.trigger_on_c_match = 1'b1;
		v = '0;
		repeat (100)
		begin
			@(negedge mclk_i);
			if (cnt > v)
				v = cnt;
		end
		chk("c_match_top", cmp, v);
		md.trigger_on_c_match = 1'b0;
		md.load_a_edge = tcc_pkg::EDGE_RISE;
		md.load_b_edge = tcc_pkg::EDGE_FALL;
		md.disable_on_b_load = 1'b1;
		pulse(3'b000, 3'b111, 1'b0);
		cap();
		chk("capture_span", 10, cb - ca);
		chk("b_load_off", 0, st.clock_running_flag);
		pulse(TRG, 3'b000, 1'b0);
		chk("trg_when_off", 0, st.clock_running_flag);
		cap();
		chk("overrun", 1, st.load_overrun_flag);
		pulse(3'b000, 3'b111, 1'b0);
		cap();
		chk("read_clears", 0, st.load_overrun_flag);
		v = cb;
		md.load_a_edge = tcc_pkg::EDGE_NONE;
		cap();
		chk("b_needs_a", v, cb);
		md = '0;
		md.wave = 1'b1;
		md.stop_on_c_match = 1'b1;
		md.eevt_src = tcc_pkg::EEVT_XC1;
		md.eevt_edge = tcc_pkg::EDGE_RISE;
		md.event_trigger_enable = 1'b1;
		tcc_pins_inst.gate = 1'b0;
		pulse(TRG, 3'b000, 1'b0);
		repeat (60) @(negedge mclk_i);
		v = cnt;
		repeat (20) @(negedge mclk_i);
		chk("c_stop", v, cnt);
		chk("c_stop_on", 1, st.clock_running_flag);
		tcc_pins_inst.gate = 1'b1;
		wait_cnt(0, 10);
		wait_cnt(8'h02, 10);
		md.disable_on_c_match = 1'b1;
		wait_cnt(cmp, 40);
		repeat (4) @(negedge mclk_i);
		chk("c_dis", 0, st.clock_running_flag);
		pulse(DIS, 3'b000, 1'b0);
		results();
	end

	initial
	begin
		repeat (20000) @(posedge mclk_i);
		err_count++;
		results();
	end

endmodule // tcc_timer_tb
